// [rtl/bpdc_pkg.sv]
// Constants shared by the port direction and data block.
// Assumes APB word access; each register index sits at byte address 4*index.
package bpdc_pkg;

  localparam int              PORT_W         = 4;
  localparam int              REG_IDX_W      = 8;
  localparam int              IDX_LSB        = 2;
  localparam int              IDX_MSB        = 9;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0]      IDX_GROUP_DIR  = 8'h27;
  localparam logic [7:0]      IDX_THIRD_DIR  = 8'h35;
  localparam logic [7:0]      IDX_B_DIR      = 8'h36;
  localparam logic [7:0]      IDX_A_DIR      = 8'h37;
  localparam logic [7:0]      IDX_A_DATA     = 8'h40;
  localparam logic [7:0]      IDX_B_DATA     = 8'h41;
  localparam logic [7:0]      IDX_THIRD_DATA = 8'h42;
  localparam logic [7:0]      IDX_GROUP_DATA = 8'h43;

  // ----------------------------------------------------------------
  // Reset values and field layouts
  // ----------------------------------------------------------------
  localparam logic [3:0]      DIR_RESET      = 4'h0;
  localparam logic [3:0]      LATCH_RESET    = 4'h0;
  localparam logic [3:0]      A_RAW_MASK     = 4'hc;
  localparam logic [3:0]      NO_RAW_MASK    = 4'h0;
  localparam logic [3:0]      ALL_OUT        = 4'hf;
  localparam logic [1:0]      ALIGN_ZERO     = 2'h0;
  localparam logic [31:0]     RDATA_ZERO     = 32'h0;

endpackage

// [rtl/bpdc_port.sv]
// One 4-bit port: direction select, output latch and read-back mux.
// Assumes the parent decodes the bus and gives one-cycle write strobes.
`timescale 1ns/1ps
`default_nettype none
module bpdc_port #(
  parameter int              W        = 4,
  parameter bit              GROUP    = 1'b0,
  parameter logic [W-1:0]    RAW_MASK = '0
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          dir_clear,
  input  wire logic          dir_wr,
  input  wire logic          data_wr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [W-1:0]  pin_in,
  output logic      [W-1:0]  pin_out,
  output logic      [W-1:0]  pin_oe,
  output logic      [W-1:0]  dir_rd,
  output logic      [W-1:0]  data_rd
);
  import bpdc_pkg::*;

  logic [W-1:0] dir_ff;
  logic [W-1:0] nxt_dir;
  logic [W-1:0] latch_ff;

  assign nxt_dir = GROUP ? {W{wdata[0]}} : wdata;

  // any reset source forces input mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_ff <= DIR_RESET[W-1:0];
    end else if (dir_clear) begin
      dir_ff <= DIR_RESET[W-1:0];
    end else if (dir_wr) begin
      dir_ff <= nxt_dir;
    end
  end

  // latch is written whatever the direction.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_ff <= LATCH_RESET[W-1:0];
    end else if (data_wr) begin
      latch_ff <= wdata;
    end
  end

  assign pin_oe  = dir_ff;
  assign pin_out = latch_ff;
  // The group select shows one bit; the upper bits are fixed at zero.
  assign dir_rd  = GROUP ? {{(W-1){1'b0}}, dir_ff[0]} : dir_ff;
  assign data_rd = (dir_ff & ~RAW_MASK & latch_ff) |
                   (~(dir_ff & ~RAW_MASK) & pin_in);

endmodule
`default_nettype wire

// [rtl/bpdc_top.sv]
// Top of the four-port direction and data block with its APB slave.
// Assumes pins are synchronous to pclk; the pad ring resolves pin levels
// from the output enables.
`timescale 1ns/1ps
`default_nettype none
module bpdc_top #(
  parameter int                        PADDR_W = 12
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [PADDR_W-1:0]      paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    clk_stop_reset,
  input  wire logic                    ce_reset,
  input  wire logic [bpdc_pkg::PORT_W-1:0] first_bit_port_in,
  output logic      [bpdc_pkg::PORT_W-1:0] first_bit_port_out,
  output logic      [bpdc_pkg::PORT_W-1:0] first_bit_port_oe,
  input  wire logic [bpdc_pkg::PORT_W-1:0] second_bit_port_in,
  output logic      [bpdc_pkg::PORT_W-1:0] second_bit_port_out,
  output logic      [bpdc_pkg::PORT_W-1:0] second_bit_port_oe,
  input  wire logic [bpdc_pkg::PORT_W-1:0] third_bit_port_in,
  output logic      [bpdc_pkg::PORT_W-1:0] third_bit_port_out,
  output logic      [bpdc_pkg::PORT_W-1:0] third_bit_port_oe,
  input  wire logic [bpdc_pkg::PORT_W-1:0] group_port_in,
  output logic      [bpdc_pkg::PORT_W-1:0] group_port_out,
  output logic      [bpdc_pkg::PORT_W-1:0] group_port_oe
);
  import bpdc_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [REG_IDX_W-1:0] reg_index(
    input logic [PADDR_W-1:0] addr
  );
    reg_index = addr[IDX_MSB:IDX_LSB];
  endfunction

  // Upper address bits must be zero, so no register has an alias.
  function automatic logic in_map(input logic [PADDR_W-1:0] addr);
    logic [REG_IDX_W-1:0] idx;
    idx = addr[IDX_MSB:IDX_LSB];
    in_map = 1'b0;
    if ((addr[1:0] == ALIGN_ZERO) && (addr[PADDR_W-1:IDX_MSB+1] == '0)) begin
      case (idx)
        IDX_GROUP_DIR, IDX_THIRD_DIR, IDX_B_DIR, IDX_A_DIR,
        IDX_A_DATA, IDX_B_DATA, IDX_THIRD_DATA, IDX_GROUP_DATA: begin
          in_map = 1'b1;
        end
        default: begin
          in_map = 1'b0;
        end
      endcase
    end
  endfunction

  logic                 mapped;
  logic [REG_IDX_W-1:0] idx;
  logic                 setup_phase;
  logic                 wr_take;
  logic                 dir_clear;

  assign mapped      = in_map(paddr);
  assign idx         = reg_index(paddr);
  assign setup_phase = psel && !penable;
  // Zero wait states: every access phase completes on its first edge.
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !mapped;
  // Only the low byte holds register bits, so pstrb[0] alone gates writes.
  assign wr_take     = psel && penable && pwrite && pstrb[0] && mapped;
  assign dir_clear   = clk_stop_reset || ce_reset;

  // ----------------------------------------------------------------
  // Ports
  // ----------------------------------------------------------------
  logic [PORT_W-1:0] a_dir_rd;
  logic [PORT_W-1:0] a_data_rd;
  logic [PORT_W-1:0] b_dir_rd;
  logic [PORT_W-1:0] b_data_rd;
  logic [PORT_W-1:0] t_dir_rd;
  logic [PORT_W-1:0] t_data_rd;
  logic [PORT_W-1:0] g_dir_rd;
  logic [PORT_W-1:0] g_data_rd;

  // first port direction at its own index.
  // two pins of the first port always read their level.
  bpdc_port #(
    .W        (PORT_W),
    .GROUP    (1'b0),
    .RAW_MASK (A_RAW_MASK)
  ) u_first (
    .pclk     (pclk),
    .presetn  (presetn),
    .dir_clear(dir_clear),
    .dir_wr   (wr_take && (idx == IDX_A_DIR)),
    .data_wr  (wr_take && (idx == IDX_A_DATA)),
    .wdata    (pwdata[PORT_W-1:0]),
    .pin_in   (first_bit_port_in),
    .pin_out  (first_bit_port_out),
    .pin_oe   (first_bit_port_oe),
    .dir_rd   (a_dir_rd),
    .data_rd  (a_data_rd)
  );

  // second port direction at its own index.
  bpdc_port #(
    .W        (PORT_W),
    .GROUP    (1'b0),
    .RAW_MASK (NO_RAW_MASK)
  ) u_second (
    .pclk     (pclk),
    .presetn  (presetn),
    .dir_clear(dir_clear),
    .dir_wr   (wr_take && (idx == IDX_B_DIR)),
    .data_wr  (wr_take && (idx == IDX_B_DATA)),
    .wdata    (pwdata[PORT_W-1:0]),
    .pin_in   (second_bit_port_in),
    .pin_out  (second_bit_port_out),
    .pin_oe   (second_bit_port_oe),
    .dir_rd   (b_dir_rd),
    .data_rd  (b_data_rd)
  );

  // third port, one bit per pin.
  bpdc_port #(
    .W        (PORT_W),
    .GROUP    (1'b0),
    .RAW_MASK (NO_RAW_MASK)
  ) u_third (
    .pclk     (pclk),
    .presetn  (presetn),
    .dir_clear(dir_clear),
    .dir_wr   (wr_take && (idx == IDX_THIRD_DIR)),
    .data_wr  (wr_take && (idx == IDX_THIRD_DATA)),
    .wdata    (pwdata[PORT_W-1:0]),
    .pin_in   (third_bit_port_in),
    .pin_out  (third_bit_port_out),
    .pin_oe   (third_bit_port_oe),
    .dir_rd   (t_dir_rd),
    .data_rd  (t_data_rd)
  );

  // group port, one select bit for all pins.
  bpdc_port #(
    .W        (PORT_W),
    .GROUP    (1'b1),
    .RAW_MASK (NO_RAW_MASK)
  ) u_group (
    .pclk     (pclk),
    .presetn  (presetn),
    .dir_clear(dir_clear),
    .dir_wr   (wr_take && (idx == IDX_GROUP_DIR)),
    .data_wr  (wr_take && (idx == IDX_GROUP_DATA)),
    .wdata    (pwdata[PORT_W-1:0]),
    .pin_in   (group_port_in),
    .pin_out  (group_port_out),
    .pin_oe   (group_port_oe),
    .dir_rd   (g_dir_rd),
    .data_rd  (g_data_rd)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unmapped reads return zero so software never sees a stale word.
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;

  // data index returns the port read-back value.
  always_comb begin
    nxt_prdata = RDATA_ZERO;
    case (idx)
      IDX_A_DIR:      nxt_prdata[PORT_W-1:0] = a_dir_rd;
      IDX_B_DIR:      nxt_prdata[PORT_W-1:0] = b_dir_rd;
      IDX_THIRD_DIR:  nxt_prdata[PORT_W-1:0] = t_dir_rd;
      IDX_GROUP_DIR:  nxt_prdata[PORT_W-1:0] = g_dir_rd;
      IDX_A_DATA:     nxt_prdata[PORT_W-1:0] = a_data_rd;
      IDX_B_DATA:     nxt_prdata[PORT_W-1:0] = b_data_rd;
      IDX_THIRD_DATA: nxt_prdata[PORT_W-1:0] = t_data_rd;
      IDX_GROUP_DATA: nxt_prdata[PORT_W-1:0] = g_data_rd;
      default:        nxt_prdata = RDATA_ZERO;
    endcase
    if (!mapped) begin
      nxt_prdata = RDATA_ZERO;
    end
  end

  // Pins are sampled in the setup cycle so the access phase needs no wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= RDATA_ZERO;
    end else if (setup_phase && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // These watch the pins, the bus outputs prdata, pslverr and pready, and the first port direction read-back.
  oe_from_dir_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$stable(second_bit_port_oe) |->
      $past(wr_take && (idx == IDX_B_DIR)) || $past(dir_clear))
    else $error("Output enable moved without a direction write.");

  a_dir_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_take && (idx == IDX_A_DIR) && !dir_clear) |=>
      (first_bit_port_oe == $past(pwdata[PORT_W-1:0])) &&
      (a_dir_rd == first_bit_port_oe))
    else $error("First port direction write did not land.");

  b_dir_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_take && (idx == IDX_B_DIR) && !dir_clear) |=>
      second_bit_port_oe == $past(pwdata[PORT_W-1:0]))
    else $error("Second port direction write did not land.");

  third_dir_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_take && (idx == IDX_THIRD_DIR) && !dir_clear) |=>
      third_bit_port_oe == $past(pwdata[PORT_W-1:0]))
    else $error("Third port direction write did not land.");

  group_oe_equal_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (group_port_oe == ALL_OUT) || (group_port_oe == DIR_RESET))
    else $error("Group port pins differ in direction.");

  dir_clear_all_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    dir_clear |=> (first_bit_port_oe == DIR_RESET) &&
      (second_bit_port_oe == DIR_RESET) &&
      (third_bit_port_oe == DIR_RESET) && (group_port_oe == DIR_RESET))
    else $error("Direction bits survived a reset source.");

  input_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && mapped && (idx == IDX_B_DATA) &&
      (second_bit_port_oe == DIR_RESET)) |=>
      prdata[PORT_W-1:0] == $past(second_bit_port_in))
    else $error("Input pin read did not return the pin level.");

  latch_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_take && (idx == IDX_THIRD_DATA)) |=>
      third_bit_port_out == $past(pwdata[PORT_W-1:0]))
    else $error("Data write did not update the output latch.");

  output_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && mapped && (idx == IDX_B_DATA) &&
      (second_bit_port_oe == ALL_OUT)) |=>
      prdata[PORT_W-1:0] == $past(second_bit_port_out))
    else $error("Output pin read did not return the latch.");

  raw_pins_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && mapped && (idx == IDX_A_DATA)) |=>
      (prdata[PORT_W-1:0] & A_RAW_MASK) ==
      ($past(first_bit_port_in) & A_RAW_MASK))
    else $error("Raw pins of the first port did not read their level.");

  unmapped_err_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !mapped) |-> pslverr && pready)
    else $error("Unmapped access was not flagged.");

  strobe_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && !pstrb[0] && !dir_clear) |=>
      $stable(first_bit_port_oe))
    else $error("Write without the low strobe changed a direction.");

  group_dir_all_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_take && (idx == IDX_GROUP_DIR) && !dir_clear) |=>
      group_port_oe == {PORT_W{$past(pwdata[0])}})
    else $error("Group direction write did not set all pins.");

  group_latch_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_take && (idx == IDX_GROUP_DATA)) |=>
      group_port_out == $past(pwdata[PORT_W-1:0]))
    else $error("Group data write did not update the latch.");

  read_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(setup_phase && !pwrite) |=> $stable(prdata))
    else $error("Read data moved without a read setup.");

endmodule
`default_nettype wire

// [test/bidirectional_port_direction_control_tb_top.sv]
// Self-checking bench for the four-port direction and data block.
// Assumes a zero-wait APB slave and a board model on every port.
`timescale 1ns/1ps
`default_nettype none
module bidirectional_port_direction_control_tb_top;
  import bpdc_pkg::*;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0;
  logic [3:0]       pstrb = 4'hf;
  logic             clk_stop_reset = 1'b0;
  logic             ce_reset = 1'b0;
  logic [3:0][3:0]  ext = 16'h0;
  logic [3:0][3:0]  ext_force = 16'h0;
  wire logic [31:0] prdata;
  wire logic        pready;
  wire logic        pslverr;
  wire logic [3:0][3:0] pin_in;
  wire logic [3:0][3:0] pin_out;
  wire logic [3:0][3:0] pin_oe;
  int               fail_count = 0;
  int               checked = 0;
  logic [31:0]      rd;
  logic             err;

  always #4 pclk = ~pclk;

  bpdc_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_stop_reset(clk_stop_reset), .ce_reset(ce_reset),
    .first_bit_port_in(pin_in[0]), .first_bit_port_out(pin_out[0]),
    .first_bit_port_oe(pin_oe[0]), .second_bit_port_in(pin_in[1]),
    .second_bit_port_out(pin_out[1]), .second_bit_port_oe(pin_oe[1]),
    .third_bit_port_in(pin_in[2]), .third_bit_port_out(pin_out[2]),
    .third_bit_port_oe(pin_oe[2]), .group_port_in(pin_in[3]),
    .group_port_out(pin_out[3]), .group_port_oe(pin_oe[3])
  );

  for (genvar g = 0; g < 4; g++) begin : g_pin
    bpdc_pin_model u_pin (
      .ext(ext[g]), .ext_force(ext_force[g]), .pin_out(pin_out[g]),
      .pin_oe(pin_oe[g]), .pin_in(pin_in[g])
    );
  end

  // ----------------------------------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= 12'({idx, ALIGN_ZERO});
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask

  // Pulses one of the synchronous resets for a single cycle.
  task automatic pulse(input int which);
    @(posedge pclk);
    if (which == 0) clk_stop_reset <= 1'b1;
    else ce_reset <= 1'b1;
    @(posedge pclk);
    clk_stop_reset <= 1'b0;
    ce_reset <= 1'b0;
    @(posedge pclk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check(32'(pin_oe), 32'h0);
    rd_chk(IDX_A_DIR, 32'h0);
    rd_chk(IDX_B_DIR, 32'h0);
  endtask

  task automatic t_bit_dir;
    apb(1'b1, IDX_A_DIR, 32'h5);
    check(32'(pin_oe[0]), 32'h5);
    apb(1'b1, IDX_B_DIR, 32'ha);
    check(32'(pin_oe[1]), 32'ha);
    apb(1'b1, IDX_THIRD_DIR, 32'h9);
    check(32'(pin_oe), 32'h09a5);
    rd_chk(IDX_A_DIR, 32'h5);
    rd_chk(IDX_B_DIR, 32'ha);
  endtask

  task automatic t_group;
    apb(1'b1, IDX_GROUP_DIR, 32'h1);
    check(32'(pin_oe[3]), 32'hf);
    apb(1'b1, IDX_GROUP_DIR, 32'hf);
    rd_chk(IDX_GROUP_DIR, 32'h1);
    apb(1'b1, IDX_GROUP_DIR, 32'he);
    check(32'(pin_oe[3]), 32'h0);
    rd_chk(IDX_GROUP_DIR, 32'h0);
  endtask

  task automatic t_data;
    ext[0] <= 4'ha;
    ext[1] <= 4'h6;
    apb(1'b1, IDX_A_DIR, 32'h0);
    apb(1'b1, IDX_A_DATA, 32'h5);
    check(32'({pin_oe[0], pin_out[0]}), 32'h05);
    rd_chk(IDX_A_DATA, 32'ha);
    apb(1'b1, IDX_A_DIR, 32'hf);
    check(32'(pin_out[0]), 32'h5);
    rd_chk(IDX_A_DATA, 32'h5);
    apb(1'b1, IDX_B_DATA, 32'h3);
    rd_chk(IDX_B_DATA, 32'h6);
  endtask

  task automatic t_sync_reset;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, IDX_B_DIR, 32'hf);
      apb(1'b1, IDX_GROUP_DIR, 32'h1);
      pulse(i);
      check(32'(pin_oe), 32'h0);
      check(32'(pin_out[0]), 32'h5);
      rd_chk(IDX_B_DIR, 32'h0);
    end
  endtask

  // Pins are overdriven so that latch and pin level differ on read-back.
  task automatic t_readback;
    @(posedge pclk);
    ext_force <= 16'hffff;
    ext[2]    <= 4'h6;
    ext[3]    <= 4'h0;
    apb(1'b1, IDX_A_DIR, 32'hf);
    rd_chk(IDX_A_DATA, 32'h9);
    apb(1'b1, IDX_B_DIR, 32'hf);
    rd_chk(IDX_B_DATA, 32'h3);
    apb(1'b1, IDX_B_DIR, 32'h0);
    rd_chk(IDX_B_DATA, 32'h6);
    apb(1'b1, IDX_THIRD_DATA, 32'hc);
    check(32'({pin_oe[2], pin_out[2]}), 32'h0c);
    rd_chk(IDX_THIRD_DATA, 32'h6);
    apb(1'b1, IDX_GROUP_DATA, 32'h9);
    apb(1'b1, IDX_GROUP_DIR, 32'h1);
    check(32'({pin_oe[3], pin_out[3]}), 32'hf9);
    rd_chk(IDX_GROUP_DATA, 32'h9);
    @(posedge pclk);
    pstrb <= 4'he;
    apb(1'b1, IDX_A_DIR, 32'h0);
    @(posedge pclk);
    pstrb <= 4'hf;
    check(32'(pin_oe[0]), 32'hf);
  endtask

  task automatic t_unmapped;
    apb(1'b0, 8'h01, 32'h0);
    check(32'({err, rd[3:0]}), 32'h10);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_bit_dir();
    t_group();
    t_data();
    t_sync_reset();
    t_readback();
    t_unmapped();
    summarize();
  end
endmodule
`default_nettype wire

// [test/bpdc_pin_model.sv]
// Board-side model of the four pins of one port.
// Assumes the block drives a pin only while its enable bit is high.
`timescale 1ns/1ps
`default_nettype none
module bpdc_pin_model (
  input  wire logic [3:0] ext,
  input  wire logic [3:0] ext_force,
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  output logic      [3:0] pin_in
);
  // driven or floating
  // A floating pin takes the board level, so a stale latch never leaks.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // A forced pin is overdriven by the board, so the level can differ
      // from the latch; this is what tells latch read-back from pin read.
      pin_in[i] = (pin_oe[i] && !ext_force[i]) ? pin_out[i] : ext[i];
    end
  end
endmodule
`default_nettype wire
